//--- shared/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

`define SPM_MAX_BYTES 50
`define SPM_LINES 20
`define SPM_CLK_MHZ 50
`define SPM_HALF_UNIT_US 5
`define SPM_HALF_UNIT_CYC (`SPM_HALF_UNIT_US * `SPM_CLK_MHZ)
`define SPM_DIV_BASE 9'h101
`define SPM_DIV_ZERO_AS 9'h100
`define SPM_FULL_BITS 4'h8
`define SPM_OPT_CPOL 1
`define SPM_OPT_CPHA 0

`endif

//--- shared/spm_pkg.sv
package spm_pkg;
  typedef enum logic [2:0] {
    SPM_IDLE = 3'b000,
    SPM_SETUP = 3'b001,
    SPM_LEAD = 3'b010,
    SPM_XFER = 3'b011,
    SPM_TRAIL = 3'b100,
    SPM_DONE = 3'b101
  } spm_state_e;
  typedef logic [4:0] spm_line_t;
  typedef logic [7:0] spm_byte_t;
endpackage

//--- shared/spm_pin_if.sv
`timescale 1ns/100ps
interface spm_pin_if;
  import spm_pkg::*;
  spm_line_t select_line;
  spm_line_t clock_line;
  spm_line_t input_line;
  spm_line_t output_line;
  logic dir_load;
  logic drive;
  logic cs_auto;
  logic sck;
  logic mosi;
  logic cs;
  logic miso;
  modport engine(output select_line, clock_line, input_line, output_line, dir_load, drive,
                 cs_auto, sck, mosi, cs, input miso);
  modport router(input select_line, clock_line, input_line, output_line, dir_load, drive,
                 cs_auto, sck, mosi, cs, output miso);
endinterface

//--- verilog/spm_pin_router.sv
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_pin_router import spm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`SPM_LINES-1:0] i_dio,
  output logic [`SPM_LINES-1:0] o_dio,
  output logic [`SPM_LINES-1:0] o_dio_oe,
  spm_pin_if.router pins
);
  function automatic logic hit(input spm_line_t line, input int idx);
    hit = (line == idx[4:0]);
  endfunction

  logic [`SPM_LINES-1:0] next_dio;
  logic [`SPM_LINES-1:0] next_oe;

  // a choice above the last line matches nothing, so such a signal goes nowhere
  assign pins.miso = (pins.input_line < `SPM_LINES) ? i_dio[pins.input_line] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < `SPM_LINES; g++) begin : g_line
    always_comb begin
      next_dio[g] = o_dio[g];
      next_oe[g] = o_dio_oe[g];
      if (pins.dir_load) begin
        if (hit(pins.select_line, g) || hit(pins.clock_line, g) || hit(pins.output_line, g))
          next_oe[g] = 1'b1;
        else if (hit(pins.input_line, g))
          next_oe[g] = 1'b0;
      end
      if (pins.drive) begin
        if (hit(pins.clock_line, g))
          next_dio[g] = pins.sck;
        else if (hit(pins.output_line, g))
          next_dio[g] = pins.mosi;
        else if (pins.cs_auto && hit(pins.select_line, g))
          next_dio[g] = pins.cs;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dio <= '0;
      o_dio_oe <= '0;
    end else begin
      o_dio <= next_dio;
      o_dio_oe <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_dir_outputs;
    @(posedge i_clk) disable iff (i_rst)
    (pins.dir_load && pins.clock_line < `SPM_LINES && pins.input_line != pins.clock_line)
      |=> o_dio_oe[$past(pins.clock_line)];
  endproperty
  a_dir_outputs: assert property (p_dir_outputs) else $error("clock line not made output");
endmodule

//--- verilog/spm_master.sv
`timescale 1ns/100ps
`include "spm_regs.svh"
// Operation
// - with auto select, select line low for whole transfer, high after last bit
// - unless skipped, set select, clock, mosi as outputs and miso as input
// - two-bit field picks clock mode A, B, C or D from 0 to 3
// - A is 0/0, B is 0/1, C is 1/0, D is 1/1 for polarity/phase
// - idle clock sits at its polarity level
// - phase 1 samples on edge toward idle, phase 0 on edge away
// - clock at idle level before select falls and before it rises again
// - clock period is 10+10*(256-divider) us, divider 0 counts as 256
// - three-bit field sets bits of final byte, 0 meaning eight; others full
// - partial final byte sends top bits and returns sampled bits at the top
// - each of the four signals routes to its own line 0 to 19
// - a transfer carries 1 to 50 bytes; other counts are not asked for
// - full duplex, one byte read while each byte is written
module spm_master import spm_pkg::*; #(
  parameter int HALF_UNIT_CYC = `SPM_HALF_UNIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_auto_chip_select,
  input wire logic i_skip_direction_setup,
  input wire logic [1:0] i_clock_mode_select,
  input wire logic [7:0] i_clock_divider_setting,
  input wire logic [2:0] i_final_bits,
  input wire logic [4:0] i_select_line_choice,
  input wire logic [4:0] i_clock_line_choice,
  input wire logic [4:0] i_input_line_choice,
  input wire logic [4:0] i_output_line_choice,
  input wire logic [5:0] i_transfer_byte_count,
  input wire logic i_tx_wr,
  input wire logic [5:0] i_tx_addr,
  input wire logic [7:0] i_tx_byte,
  input wire logic [5:0] i_rx_addr,
  input wire logic [`SPM_LINES-1:0] i_dio,
  output logic [`SPM_LINES-1:0] o_dio,
  output logic [`SPM_LINES-1:0] o_dio_oe,
  output logic [7:0] o_rx_byte,
  output logic o_busy,
  output logic o_done,
  output logic [5:0] o_completed_byte_count
);
  spm_pin_if pins();

  spm_byte_t tx_mem [`SPM_MAX_BYTES];
  spm_byte_t rx_mem [`SPM_MAX_BYTES];

  spm_state_e state, next_state;
  logic [16:0] timer, next_timer, half_len, next_half_len;
  logic phase, next_phase, sck, next_sck, mosi, next_mosi, cs, next_cs;
  logic dir_load, next_dir_load, busy, next_busy, done, next_done;
  spm_byte_t tx, next_tx, rx, next_rx, rx_new, rx_wdata;
  logic [3:0] bit_cnt, next_bit_cnt, bits_this;
  logic [5:0] byte_idx, next_byte_idx, count, next_count, completed, next_completed;
  logic [1:0] mode, next_mode;
  logic auto_cs, next_auto_cs, skip, next_skip;
  logic [2:0] nbits, next_nbits;
  spm_line_t sel_l, next_sel_l, clk_l, next_clk_l, in_l, next_in_l, out_l, next_out_l;
  logic rx_we, lead, sample, last_byte;
  logic [8:0] fac;

  assign pins.select_line = sel_l;
  assign pins.clock_line = clk_l;
  assign pins.input_line = in_l;
  assign pins.output_line = out_l;
  assign pins.dir_load = dir_load;
  assign pins.drive = busy;
  assign pins.cs_auto = auto_cs;
  assign pins.sck = sck;
  assign pins.mosi = mosi;
  assign pins.cs = cs;

  spm_pin_router spm_pin_router_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_dio(i_dio),
    .o_dio(o_dio),
    .o_dio_oe(o_dio_oe),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    fac = (i_clock_divider_setting == 8'h00) ? `SPM_DIV_ZERO_AS : {1'b0, i_clock_divider_setting};
    last_byte = (byte_idx == count - 6'h01);
    bits_this = (last_byte && nbits != 3'h0) ? {1'b0, nbits} : `SPM_FULL_BITS;
    lead = ~phase;
    sample = (lead != mode[`SPM_OPT_CPHA]);
    rx_new = sample ? {rx[6:0], pins.miso} : rx;
    rx_wdata = rx_new << (`SPM_FULL_BITS - bits_this);
    rx_we = 1'b0;
    next_state = state;
    next_timer = timer;
    next_half_len = half_len;
    next_phase = phase;
    next_sck = sck;
    next_mosi = mosi;
    next_cs = cs;
    next_dir_load = 1'b0;
    next_busy = busy;
    next_done = 1'b0;
    next_tx = tx;
    next_rx = rx;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_count = count;
    next_completed = completed;
    next_mode = mode;
    next_auto_cs = auto_cs;
    next_skip = skip;
    next_nbits = nbits;
    next_sel_l = sel_l;
    next_clk_l = clk_l;
    next_in_l = in_l;
    next_out_l = out_l;
    case (state)
      SPM_IDLE: begin
        // out-of-range counts are dropped rather than clipped
        if (i_start && i_transfer_byte_count != 6'h00 &&
            i_transfer_byte_count <= `SPM_MAX_BYTES) begin
          next_state = SPM_SETUP;
          next_busy = 1'b1;
          next_completed = 6'h00;
          next_count = i_transfer_byte_count;
          next_mode = i_clock_mode_select;
          // new idle level is taken with the request, so set-up never shows the old one
          next_sck = i_clock_mode_select[`SPM_OPT_CPOL];
          next_auto_cs = i_auto_chip_select;
          next_skip = i_skip_direction_setup;
          next_nbits = i_final_bits;
          next_sel_l = i_select_line_choice;
          next_clk_l = i_clock_line_choice;
          next_in_l = i_input_line_choice;
          next_out_l = i_output_line_choice;
          next_half_len = 17'(HALF_UNIT_CYC * int'(`SPM_DIV_BASE - fac));
        end
      end
      SPM_SETUP: begin
        next_sck = mode[`SPM_OPT_CPOL];
        next_cs = 1'b1;
        next_dir_load = ~skip;
        next_byte_idx = 6'h00;
        next_bit_cnt = 4'h0;
        next_phase = 1'b0;
        next_timer = half_len - 17'h1;
        next_tx = tx_mem[0];
        if (!mode[`SPM_OPT_CPHA]) begin
          next_mosi = tx_mem[0][7];
          next_tx = tx_mem[0] << 1;
        end
        next_state = SPM_LEAD;
      end
      SPM_LEAD: begin
        next_cs = 1'b0;
        if (timer != 17'h0) next_timer = timer - 17'h1;
        else begin
          next_timer = half_len - 17'h1;
          next_state = SPM_XFER;
        end
      end
      SPM_XFER: begin
        if (timer != 17'h0) next_timer = timer - 17'h1;
        else begin
          next_timer = half_len - 17'h1;
          next_sck = ~sck;
          next_phase = ~phase;
          next_rx = rx_new;
          if (lead) begin
            if (mode[`SPM_OPT_CPHA]) begin
              next_mosi = tx[7];
              next_tx = tx << 1;
            end
          end else if (bit_cnt == bits_this - 4'h1) begin
            rx_we = 1'b1;
            next_bit_cnt = 4'h0;
            next_completed = byte_idx + 6'h01;
            if (last_byte) next_state = SPM_TRAIL;
            else begin
              next_byte_idx = byte_idx + 6'h01;
              next_tx = tx_mem[byte_idx + 6'h01];
              if (!mode[`SPM_OPT_CPHA]) begin
                next_mosi = tx_mem[byte_idx + 6'h01][7];
                next_tx = tx_mem[byte_idx + 6'h01] << 1;
              end
            end
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (!mode[`SPM_OPT_CPHA]) begin
              next_mosi = tx[7];
              next_tx = tx << 1;
            end
          end
        end
      end
      SPM_TRAIL: begin
        // sck already back at idle here, so select rises after it
        if (timer != 17'h0) next_timer = timer - 17'h1;
        else begin
          next_cs = 1'b1;
          next_state = SPM_DONE;
        end
      end
      SPM_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = SPM_IDLE;
      end
      default: next_state = SPM_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SPM_IDLE;
      timer <= '0;
      half_len <= '0;
      phase <= 1'b0;
      sck <= 1'b0;
      mosi <= 1'b0;
      cs <= 1'b1;
      dir_load <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      tx <= '0;
      rx <= '0;
      bit_cnt <= '0;
      byte_idx <= '0;
      count <= '0;
      completed <= '0;
      mode <= '0;
      auto_cs <= 1'b0;
      skip <= 1'b0;
      nbits <= '0;
      sel_l <= '0;
      clk_l <= '0;
      in_l <= '0;
      out_l <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      half_len <= next_half_len;
      phase <= next_phase;
      sck <= next_sck;
      mosi <= next_mosi;
      cs <= next_cs;
      dir_load <= next_dir_load;
      busy <= next_busy;
      done <= next_done;
      tx <= next_tx;
      rx <= next_rx;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      count <= next_count;
      completed <= next_completed;
      mode <= next_mode;
      auto_cs <= next_auto_cs;
      skip <= next_skip;
      nbits <= next_nbits;
      sel_l <= next_sel_l;
      clk_l <= next_clk_l;
      in_l <= next_in_l;
      out_l <= next_out_l;
    end
  end

  // memories carry no reset; contents are only meaningful after a write
  always_ff @(posedge i_clk) begin
    if (i_tx_wr && i_tx_addr < `SPM_MAX_BYTES) tx_mem[i_tx_addr] <= i_tx_byte;
    if (rx_we) rx_mem[byte_idx] <= rx_wdata;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_byte <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_completed_byte_count <= '0;
    end else begin
      o_rx_byte <= (i_rx_addr < `SPM_MAX_BYTES) ? rx_mem[i_rx_addr] : 8'h00;
      o_busy <= next_busy;
      o_done <= next_done;
      o_completed_byte_count <= next_completed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [16:0] gap;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) gap <= '0;
    else if (sck != next_sck || state != SPM_XFER) gap <= '0;
    else gap <= gap + 17'h1;
  end

  sequence s_select_drop;
    state == SPM_LEAD && $past(state) == SPM_SETUP;
  endsequence
  sequence s_idle_clock;
    sck == mode[`SPM_OPT_CPOL];
  endsequence

  property p_cs_low;
    state == SPM_XFER |-> cs == 1'b0;
  endproperty
  a_cs_low: assert property (p_cs_low) else $error("select high during transfer");
  property p_dir_pulse;
    state == SPM_SETUP |=> dir_load == !skip;
  endproperty
  a_dir_pulse: assert property (p_dir_pulse) else $error("direction setup wrong");
  property p_mode_map;
    state == SPM_LEAD |-> sck == mode[`SPM_OPT_CPOL];
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("idle level not from mode");
  property p_idle_level;
    state != SPM_XFER && busy |-> s_idle_clock;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not idle");
  property p_select_order;
    s_select_drop |-> s_idle_clock ##1 (cs == 1'b0 && sck == $past(sck));
  endproperty
  a_select_order: assert property (p_select_order) else $error("clock moved at select");
  property p_rise_idle;
    $rose(cs) |-> s_idle_clock;
  endproperty
  a_rise_idle: assert property (p_rise_idle) else $error("select rose with clock active");
  property p_half_period;
    state == SPM_XFER && sck != next_sck |-> gap == half_len - 17'h1;
  endproperty
  a_half_period: assert property (p_half_period) else $error("half period wrong");
  property p_sample_edge;
    state == SPM_XFER && timer == 17'h0 && sample
      |=> (sck != mode[`SPM_OPT_CPOL]) == !mode[`SPM_OPT_CPHA];
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sampled on wrong edge");
  property p_partial_align;
    rx_we && last_byte && nbits != 3'h0 |-> (rx_wdata & (8'hFF >> nbits)) == 8'h00;
  endproperty
  a_partial_align: assert property (p_partial_align) else $error("partial byte misaligned");
  property p_done_count;
    o_done |-> o_completed_byte_count == count && !o_busy;
  endproperty
  a_done_count: assert property (p_done_count) else $error("byte count mismatch");
  property p_bad_count;
    state == SPM_IDLE && i_start && i_transfer_byte_count == 6'h00 |=> state == SPM_IDLE;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("empty transfer started");
endmodule

//--- sim/spm_slave_model.sv
`timescale 1ns/100ps
module spm_slave_model (
  input wire logic i_clk,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_cpol,
  input wire logic i_cpha,
  output logic o_miso
);
  logic [7:0] resp [0:49];
  logic [7:0] got [0:49];
  int cnt = 0;
  int oidx = 0;
  logic tg = 1'b0;
  // released line has no pull, so it wanders instead of holding the last bit
  always @(posedge i_clk) tg <= ~tg;
  always @(negedge i_cs_n) begin
    cnt = 0;
    oidx = 0;
    foreach (got[k]) got[k] = 8'h00;
  end
  always @(i_sck) begin
    if (i_cs_n === 1'b0) begin
      if ((i_sck != i_cpol) == !i_cpha) begin
        if (cnt < 400) got[cnt/8][7-cnt%8] = i_mosi;
        cnt++;
      end else begin
        oidx = cnt;
      end
    end
  end
  assign o_miso = (i_cs_n === 1'b0 && oidx < 400) ? resp[oidx/8][7-oidx%8] : tg;
endmodule

//--- sim/spm_master_transfer_tb_top.sv
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_master_transfer_tb_top;
  logic i_clk, i_rst, start, auto_cs, skip, tx_wr, busy, done, s_miso, tog, manual, man_cs_n;
  logic active, sck_q, cs_q, low_seen, fell, seen, cpol, frame, fq;
  logic [1:0] mode;
  logic [7:0] div, tx_byte, rx_byte;
  logic [2:0] fb;
  logic [4:0] se, ck, mi, mo;
  logic [5:0] count, tx_addr, rx_addr, done_cnt;
  logic [`SPM_LINES-1:0] o_dio, oe, dio;
  logic [7:0] txm [0:49];
  int num_errors = 0;
  int tests_run = 0;
  int hp, exp_h;
  integer seed = 32'h08400018;
  logic [5:0] seed_bad [0:2] = '{6'h00, 6'h33, 6'h3F};
  ////////////////////////////////////////////////////////////////////////////
  for (genvar k = 0; k < `SPM_LINES; k++) begin : g_wire
    assign dio[k] = oe[k] ? o_dio[k] : (k == mi ? s_miso : tog);
  end
  spm_master #(.HALF_UNIT_CYC(2)) spm_master_i (.i_clk(i_clk), .i_rst(i_rst), .i_start(start),
    .i_auto_chip_select(auto_cs), .i_skip_direction_setup(skip), .i_clock_mode_select(mode),
    .i_clock_divider_setting(div), .i_final_bits(fb), .i_select_line_choice(se),
    .i_clock_line_choice(ck), .i_input_line_choice(mi), .i_output_line_choice(mo),
    .i_transfer_byte_count(count), .i_tx_wr(tx_wr), .i_tx_addr(tx_addr), .i_tx_byte(tx_byte),
    .i_rx_addr(rx_addr), .i_dio(dio), .o_dio(o_dio), .o_dio_oe(oe), .o_rx_byte(rx_byte),
    .o_busy(busy), .o_done(done), .o_completed_byte_count(done_cnt));
  spm_slave_model spm_slave_model_i (.i_clk(i_clk), .i_sck(dio[ck]),
    .i_cs_n(manual ? man_cs_n : dio[se]), .i_mosi(dio[mo]), .i_cpol(mode >= 2'h2),
    .i_cpha(mode[0]), .o_miso(s_miso));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) tog <= ~tog;
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task conclude;
    $display("comparisons %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // edge spacing and select framing, only while the engine owns the lines
  always @(posedge i_clk) begin
    #1;
    hp++;
    // edges count only inside a settled select frame; idle set-up and stale lines are skipped
    frame = busy && (manual ? !man_cs_n : !dio[se]);
    if (active && frame && fq && oe[ck] && dio[ck] !== sck_q) begin
      if (seen) check("sck half period", exp_h, hp);
      seen = 1'b1;
      hp = 0;
    end
    if (active && !manual && oe[se] && oe[ck] && dio[se] !== cs_q) begin
      if (!dio[se] || low_seen) check("sck at select edge", cpol, dio[ck]);
      low_seen = !dio[se];
      if (!dio[se]) fell = 1'b1;
    end
    sck_q = dio[ck];
    cs_q = dio[se];
    fq = frame;
  end
  task rd(input int a, input logic [7:0] e);
    @(posedge i_clk) rx_addr <= a[5:0];
    @(posedge i_clk);
    #1 check("rx byte", e, rx_byte);
  endtask
  task xfer(input int n, input int f, input int m, input int d, input bit a, input bit s,
            input bit man, input bit mon);
    int k, lim, l0, l1, l2;
    logic [7:0] mask;
    // odd counts get a zero pad byte so the payload fills whole 16-bit words
    for (k = 0; k < 2 * ((n + 1) / 2); k++) begin
      txm[k] = (k < n) ? $random(seed) : 8'h00;
      spm_slave_model_i.resp[k] = $random(seed);
      @(posedge i_clk);
      tx_wr <= 1'b1;
      tx_addr <= k[5:0];
      tx_byte <= txm[k];
    end
    l0 = {$random(seed)} % 20;
    l1 = (l0 + 1 + {$random(seed)} % 5) % 20;
    l2 = (l1 + 1 + {$random(seed)} % 5) % 20;
    @(posedge i_clk);
    tx_wr <= 1'b0;
    se <= l0[4:0];
    ck <= l1[4:0];
    mi <= l2[4:0];
    mo <= 5'((l2 + 1 + {$random(seed)} % 5) % 20);
    count <= n[5:0];
    fb <= f[2:0];
    mode <= m[1:0];
    div <= d[7:0];
    auto_cs <= a;
    skip <= s;
    manual <= man;
    start <= 1'b1;
    cpol = (m >= 2);
    exp_h = 2 * (`SPM_DIV_BASE - (d == 0 ? `SPM_DIV_ZERO_AS : d));
    {seen, fell, low_seen, active} = {3'b000, mon};
    @(posedge i_clk) start <= 1'b0;
    if (man) begin
      repeat (2) @(posedge i_clk);
      #1 check("sck idle before manual select", cpol, dio[ck]);
      @(posedge i_clk) man_cs_n <= 1'b0;
    end
    lim = 0;
    do begin
      @(posedge i_clk);
      #1 lim++;
    end while (done !== 1'b1 && lim < 40000);
    if (lim >= 40000) begin
      check("done within bound", 1, 0);
      conclude();
    end
    check("bytes exchanged", n, done_cnt);
    if (s) check("directions kept", 0, oe);
    else check("directions", 3'b111, {oe[se], oe[ck], oe[mo], oe[mi]} >> 1);
    if (!s) check("input line direction", 0, oe[mi]);
    if (mon) check("sck idle after", cpol, dio[ck]);
    if (mon && !man) check("select framed", 2'b11, {fell, dio[se]});
    @(posedge i_clk) man_cs_n <= 1'b1;
    active = 1'b0;
    for (k = 0; k < n && mon; k++) begin
      mask = (k == n - 1 && f != 0) ? 8'hFF << (8 - f) : 8'hFF;
      rd(k, spm_slave_model_i.resp[k] & mask);
      check("slave saw", txm[k] & mask, spm_slave_model_i.got[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, start, auto_cs, skip, tx_wr, manual, man_cs_n, tog, active} = 9'b100000100;
    {mode, div, fb, se, ck, mi, mo, count, tx_addr, tx_byte, rx_addr} = '0;
    hp = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    xfer(1, 0, 0, 255, 1, 1, 0, 0);
    for (int i = 0; i < 8; i++) begin
      xfer(i == 0 ? 50 : i == 1 ? 1 : 1 + {$random(seed)} % 50, {$random(seed)} % 8, i % 4,
           255 - i % 3, 1, 0, 0, 1);
    end
    xfer(3, 5, 3, 254, 0, 0, 1, 1);
    xfer(1, 1, 0, 0, 1, 0, 0, 1);
    foreach (seed_bad[j]) begin
      @(posedge i_clk);
      count <= seed_bad[j];
      start <= 1'b1;
      @(posedge i_clk) start <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1 check("busy after bad count", 0, busy);
    end
    rd(50, 8'h00);
    conclude();
  end
endmodule
